// *** design/bxa_params.svh ***
`ifndef BXA_PARAMS_SVH
`define BXA_PARAMS_SVH

// Register byte offsets
`define BXA_OFS_WORK 8'h00
`define BXA_OFS_FADDR 8'h04
`define BXA_OFS_FDATA 8'h08
`define BXA_OFS_STAT 8'h0C
`define BXA_OFS_CMD 8'h10
`define BXA_OFS_RES 8'h14

// Status bit positions
`define BXA_ST_C 0
`define BXA_ST_DIG 1
`define BXA_ST_Z 2

// Command fields
`define BXA_CMD_LIT_MSB 7
`define BXA_CMD_OP_LSB 8
`define BXA_CMD_OP_MSB 9
`define BXA_CMD_DST 10
`define BXA_CMD_MSB 10

// Reset values
`define BXA_WORK_RST 8'h00
`define BXA_FADDR_RST 7'h00
`define BXA_STAT_RST 3'h0
`define BXA_CMD_RST 11'h000
`define BXA_RES_RST 8'h00

// Only whole-word transfers are taken
`define BXA_HSIZE_WORD 3'h2

`endif

// *** design/bxa_pkg.sv ***
package bxa_pkg;

    typedef enum logic [1:0] {
        BXA_OP_SUB = 2'b00,
        BXA_OP_XORL = 2'b01,
        BXA_OP_SWAP = 2'b10,
        BXA_OP_XORF = 2'b11
    } bxa_op_t;

    typedef enum logic [1:0] {
        BXA_PH_IDLE = 2'b00,
        BXA_PH_WRITE = 2'b01,
        BXA_PH_RWAIT = 2'b10,
        BXA_PH_RDATA = 2'b11
    } bxa_phase_t;

    function automatic logic bxa_is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction : bxa_is_zero

endpackage : bxa_pkg

// *** design/bxa_if.sv ***
`timescale 1ns/1ps

interface bxa_alu_if
    import bxa_pkg::*;
    ();
    logic [7:0] work;
    logic [7:0] file;
    logic [7:0] literal;
    bxa_op_t op;
    logic dest;
    logic [7:0] result;
    logic c;
    logic dig_carry;
    logic z;
    logic upd_c;
    logic upd_dig;
    logic upd_z;
    logic to_file;

    modport core (
        output work, file, literal, op, dest,
        input result, c, dig_carry, z, upd_c, upd_dig, upd_z, to_file
    );
    modport alu (
        input work, file, literal, op, dest,
        output result, c, dig_carry, z, upd_c, upd_dig, upd_z, to_file
    );
endinterface : bxa_alu_if

interface bxa_mem_if;
    logic [6:0] addr;
    logic we;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport core (output addr, we, wdata, input rdata);
    modport mem (input addr, we, wdata, output rdata);
endinterface : bxa_mem_if

// *** design/bxa_file.sv ***
`timescale 1ns/1ps

module bxa_file #(
    parameter int DEPTH = 128
) (
    // Clock
    input wire logic clk,
    // Access port
    bxa_mem_if.mem m
);
    logic [7:0] mem_r [DEPTH];

    // Asynchronous read so an operation sees its operand in the same cycle
    assign m.rdata = mem_r[m.addr];

    always_ff @(posedge clk)
    begin
        if (m.we)
        begin
            mem_r[m.addr] <= m.wdata;
        end
    end
endmodule : bxa_file

// *** design/bxa_alu.sv ***
`timescale 1ns/1ps

module bxa_alu
    import bxa_pkg::*;
(
    // Operands and results
    bxa_alu_if.alu a
);
    logic [8:0] diff;
    logic [7:0] swapped;
    logic is_sub;
    logic is_xorl;
    logic is_swap;

    assign is_sub = a.op == BXA_OP_SUB;
    assign is_xorl = a.op == BXA_OP_XORL;
    assign is_swap = a.op == BXA_OP_SWAP;

    // Borrow out lands in bit 8
    assign diff = {1'b0, a.file} - {1'b0, a.work};
    assign swapped = {a.file[3:0], a.file[7:4]};

    assign a.result = is_sub ? diff[7:0] :
                      is_xorl ? (a.work ^ a.literal) :
                      is_swap ? swapped :
                      (a.work ^ a.file);

    // Literal form always lands in the working register
    assign a.to_file = a.dest & ~is_xorl;

    assign a.c = ~diff[8];
    assign a.dig_carry = a.work[3:0] <= a.file[3:0];
    assign a.z = bxa_is_zero(a.result);
    assign a.upd_c = is_sub;
    assign a.upd_dig = is_sub;
    assign a.upd_z = ~is_swap;
endmodule : bxa_alu

// *** design/bxa_top.sv ***
`timescale 1ns/1ps
`include "bxa_params.svh"

module bxa_top
    import bxa_pkg::*;
#(
    parameter int FILE_DEPTH = 128
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite address phase
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    // AHB-Lite data phase
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    bxa_phase_t phase_r;
    bxa_phase_t phase_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic [7:0] work_r;
    logic [7:0] work_nxt;
    logic [6:0] faddr_r;
    logic [6:0] faddr_nxt;
    logic [2:0] stat_r;
    logic [2:0] stat_nxt;
    logic [`BXA_CMD_MSB:0] cmd_r;
    logic [`BXA_CMD_MSB:0] cmd_nxt;
    logic [7:0] res_r;
    logic [7:0] res_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] rd_mux;

    bxa_alu_if alu_bus ();
    bxa_mem_if mem_bus ();

    bxa_alu u_alu (
        .a(alu_bus.alu)
    );

    bxa_file #(
        .DEPTH(FILE_DEPTH)
    ) u_file (
        .clk(hclk),
        .m(mem_bus.mem)
    );

    // Bus decode; sub-word transfers are ignored but still answered OKAY
    wire take = hsel & htrans[1] & hready & (hsize == `BXA_HSIZE_WORD);
    wire wr_ph = phase_r == BXA_PH_WRITE;
    wire sel_work = addr_r == `BXA_OFS_WORK;
    wire sel_faddr = addr_r == `BXA_OFS_FADDR;
    wire sel_fdata = addr_r == `BXA_OFS_FDATA;
    wire sel_stat = addr_r == `BXA_OFS_STAT;
    wire sel_cmd = addr_r == `BXA_OFS_CMD;
    wire sel_res = addr_r == `BXA_OFS_RES;
    wire wr_work = wr_ph & sel_work;
    wire wr_faddr = wr_ph & sel_faddr;
    wire wr_fdata = wr_ph & sel_fdata;
    wire wr_stat = wr_ph & sel_stat;
    wire cmd_wr = wr_ph & sel_cmd;
    wire [7:0] file_rd = mem_bus.rdata;

    assign addr_nxt = take ? haddr[7:0] : addr_r;

    // Read data is registered, so every taken read costs one wait state
    always_comb
    begin
        case (phase_r)
            BXA_PH_RWAIT: phase_nxt = BXA_PH_RDATA;
            BXA_PH_IDLE,
            BXA_PH_WRITE,
            BXA_PH_RDATA:
            begin
                if (take)
                begin
                    phase_nxt = hwrite ? BXA_PH_WRITE : BXA_PH_RWAIT;
                end
                else
                begin
                    phase_nxt = BXA_PH_IDLE;
                end
            end
            default: phase_nxt = BXA_PH_IDLE;
        endcase
    end

    // Operation is issued by the command write itself
    assign alu_bus.work = work_r;
    assign alu_bus.file = file_rd;
    assign alu_bus.literal = hwdata[`BXA_CMD_LIT_MSB:0];
    assign alu_bus.op = bxa_op_t'(hwdata[`BXA_CMD_OP_MSB:`BXA_CMD_OP_LSB]);
    assign alu_bus.dest = hwdata[`BXA_CMD_DST];

    wire op_to_work = cmd_wr & ~alu_bus.to_file;
    wire op_to_file = cmd_wr & alu_bus.to_file;

    assign mem_bus.addr = faddr_r;
    assign mem_bus.we = wr_fdata | op_to_file;
    assign mem_bus.wdata = cmd_wr ? alu_bus.result : hwdata[7:0];

    assign work_nxt = wr_work ? hwdata[7:0] :
                      op_to_work ? alu_bus.result :
                      work_r;
    assign faddr_nxt = wr_faddr ? hwdata[6:0] : faddr_r;
    assign cmd_nxt = cmd_wr ? hwdata[`BXA_CMD_MSB:0] : cmd_r;
    assign res_nxt = cmd_wr ? alu_bus.result : res_r;

    // Flags move only where the operation owns them
    assign stat_nxt[`BXA_ST_C] = wr_stat ? hwdata[`BXA_ST_C] :
                                 (cmd_wr & alu_bus.upd_c) ? alu_bus.c :
                                 stat_r[`BXA_ST_C];
    assign stat_nxt[`BXA_ST_DIG] = wr_stat ? hwdata[`BXA_ST_DIG] :
                                   (cmd_wr & alu_bus.upd_dig) ? alu_bus.dig_carry :
                                   stat_r[`BXA_ST_DIG];
    assign stat_nxt[`BXA_ST_Z] = wr_stat ? hwdata[`BXA_ST_Z] :
                                 (cmd_wr & alu_bus.upd_z) ? alu_bus.z :
                                 stat_r[`BXA_ST_Z];

    assign rd_mux = sel_work ? {24'h000000, work_r} :
                    sel_faddr ? {25'h0000000, faddr_r} :
                    sel_fdata ? {24'h000000, file_rd} :
                    sel_stat ? {29'h00000000, stat_r} :
                    sel_cmd ? {21'h000000, cmd_r} :
                    sel_res ? {24'h000000, res_r} :
                    32'h00000000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_r <= BXA_PH_IDLE;
            addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end
        else
        begin
            phase_r <= phase_nxt;
            addr_r <= addr_nxt;
            if (phase_r == BXA_PH_RWAIT)
            begin
                hrdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            work_r <= `BXA_WORK_RST;
            faddr_r <= `BXA_FADDR_RST;
            stat_r <= `BXA_STAT_RST;
            cmd_r <= `BXA_CMD_RST;
            res_r <= `BXA_RES_RST;
        end
        else
        begin
            work_r <= work_nxt;
            faddr_r <= faddr_nxt;
            stat_r <= stat_nxt;
            cmd_r <= cmd_nxt;
            res_r <= res_nxt;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = phase_r != BXA_PH_RWAIT;
    assign hresp = 1'b0;

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wire [1:0] cmd_op = hwdata[`BXA_CMD_OP_MSB:`BXA_CMD_OP_LSB];
    wire cmd_dst = hwdata[`BXA_CMD_DST];
    wire sub_go = cmd_wr && cmd_op == BXA_OP_SUB;
    wire xorl_go = cmd_wr && cmd_op == BXA_OP_XORL;
    wire swap_go = cmd_wr && cmd_op == BXA_OP_SWAP;
    wire xorf_go = cmd_wr && cmd_op == BXA_OP_XORF;

    property p_sub_to_work;
        sub_go && !cmd_dst |=> work_r == 8'($past(file_rd) - $past(work_r));
    endproperty
    a_sub_to_work: assert property (p_sub_to_work)
        else $error("subtract result not in working register");

    property p_sub_to_file;
        sub_go && cmd_dst |=> file_rd == 8'($past(file_rd) - $past(work_r))
            && $stable(work_r);
    endproperty
    a_sub_to_file: assert property (p_sub_to_file)
        else $error("subtract result not written back to file");

    property p_sub_carry;
        sub_go |=> stat_r[`BXA_ST_C] == ($past(work_r) <= $past(file_rd));
    endproperty
    a_sub_carry: assert property (p_sub_carry)
        else $error("subtract carry wrong");

    property p_sub_digit;
        sub_go |=> stat_r[`BXA_ST_DIG] == ($past(work_r[3:0]) <= $past(file_rd[3:0]));
    endproperty
    a_sub_digit: assert property (p_sub_digit)
        else $error("subtract digit carry wrong");

    property p_xorl;
        xorl_go |=> work_r == ($past(work_r) ^ $past(hwdata[7:0]))
            && stat_r[1:0] == $past(stat_r[1:0]);
    endproperty
    a_xorl: assert property (p_xorl)
        else $error("literal xor wrong or touched carry flags");

    property p_swap;
        swap_go |=> stat_r == $past(stat_r)
            && (cmd_r[`BXA_CMD_DST] ? file_rd : work_r)
               == {$past(file_rd[3:0]), $past(file_rd[7:4])};
    endproperty
    a_swap: assert property (p_swap)
        else $error("nibble swap wrong or flags changed");

    property p_xorf;
        xorf_go |=> stat_r[1:0] == $past(stat_r[1:0])
            && (cmd_r[`BXA_CMD_DST] ? file_rd : work_r)
               == ($past(work_r) ^ $past(file_rd));
    endproperty
    a_xorf: assert property (p_xorf)
        else $error("file xor wrong or touched carry flags");

    property p_zero;
        cmd_wr && cmd_op != BXA_OP_SWAP |=> stat_r[`BXA_ST_Z] == (res_r == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag does not match result");

    property p_read_wait;
        take && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state wrong");

    property p_write_ready;
        take && hwrite |=> hreadyout;
    endproperty
    a_write_ready: assert property (p_write_ready)
        else $error("write data phase stalled");

    property p_xorl_dest;
        xorl_go && cmd_dst |=> file_rd == $past(file_rd);
    endproperty
    a_xorl_dest: assert property (p_xorl_dest)
        else $error("literal xor touched the file byte");

    property p_swap_file;
        swap_go && cmd_dst |=> work_r == $past(work_r);
    endproperty
    a_swap_file: assert property (p_swap_file)
        else $error("swap to file changed working register");

    property p_xorf_file;
        xorf_go && cmd_dst |=> work_r == $past(work_r);
    endproperty
    a_xorf_file: assert property (p_xorf_file)
        else $error("file xor to file changed working register");

    property p_zero_sub;
        sub_go |=> stat_r[`BXA_ST_Z] == ($past(file_rd) == $past(work_r));
    endproperty
    a_zero_sub: assert property (p_zero_sub)
        else $error("subtract zero flag wrong");

    property p_zero_xorl;
        xorl_go |=> stat_r[`BXA_ST_Z] == ($past(work_r) == $past(hwdata[7:0]));
    endproperty
    a_zero_xorl: assert property (p_zero_xorl)
        else $error("literal xor zero flag wrong");

    property p_zero_xorf;
        xorf_go |=> stat_r[`BXA_ST_Z] == ($past(work_r) == $past(file_rd));
    endproperty
    a_zero_xorf: assert property (p_zero_xorf)
        else $error("file xor zero flag wrong");

    c_sub_borrow: cover property (sub_go && work_r > file_rd);
    c_sub_to_file: cover property (sub_go && cmd_dst);
    c_xor_zero: cover property (xorf_go ##1 stat_r[`BXA_ST_Z]);
    c_swap: cover property (swap_go);
endmodule : bxa_top

// *** bench/bxa_tb.sv ***
`timescale 1ns/1ps
`include "bxa_params.svh"

module tb
    import bxa_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    int n_fail = 0;
    int n_tests = 0;

    bxa_top dut_u (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hreadyout),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp)
    );

    initial
    begin
        forever #2 hclk = ~hclk;
    end

    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Caller is just after a rising edge; hreadyout acts as hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        n = 0;
        // Taken reads must show exactly one wait state, all else none
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
        chk(n, (w || hsize != 3'h2) ? 32'h1 : 32'h2);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rdc

    // Load operands, execute, then read back every affected place
    task automatic run(input logic [1:0] op, input logic d, input logic [7:0] k,
                       input logic [7:0] w, input logic [7:0] f, input logic [2:0] s0,
                       input logic [7:0] er, input logic [2:0] es);
        logic tf;
        tf = d && op != 2'h1;
        wr(`BXA_OFS_FADDR, 32'h5A);
        wr(`BXA_OFS_FDATA, {24'h0, f});
        wr(`BXA_OFS_WORK, {24'h0, w});
        wr(`BXA_OFS_STAT, {29'h0, s0});
        wr(`BXA_OFS_CMD, {21'h0, d, op, k});
        rdc(`BXA_OFS_RES, {24'h0, er});
        rdc(`BXA_OFS_WORK, {24'h0, tf ? w : er});
        rdc(`BXA_OFS_FDATA, {24'h0, tf ? er : f});
        rdc(`BXA_OFS_STAT, {29'h0, es});
    endtask : run

    task automatic t_regs();
        rdc(`BXA_OFS_WORK, 32'h0);
        rdc(`BXA_OFS_STAT, 32'h0);
        rdc(`BXA_OFS_RES, 32'h0);
        wr(`BXA_OFS_FADDR, 32'hFFFF_FFFF);
        rdc(`BXA_OFS_FADDR, 32'h7F);
        wr(8'h18, 32'hFF);
        rdc(8'h18, 32'h0);
        wr(`BXA_OFS_RES, 32'hFF);
        rdc(`BXA_OFS_RES, 32'h0);
        hsize <= 3'h0;
        wr(`BXA_OFS_WORK, 32'hFF);
        hsize <= 3'h2;
        rdc(`BXA_OFS_WORK, 32'h0);
        hsel <= 1'b0;
        wr(`BXA_OFS_WORK, 32'hFF);
        hsel <= 1'b1;
        rdc(`BXA_OFS_WORK, 32'h0);
    endtask : t_regs

    // Equal operands, each nibble boundary, and full wrap
    task automatic t_sub();
        logic [7:0] wv [6] = '{8'h05, 8'h06, 8'h1F, 8'h10, 8'h00, 8'hFF};
        logic [7:0] fv [6] = '{8'h05, 8'h05, 8'h20, 8'h0F, 8'hFF, 8'h00};
        logic [7:0] e;
        for (int i = 0; i < 6; i++)
        begin
            e = fv[i] - wv[i];
            run(BXA_OP_SUB, i[0], 8'h00, wv[i], fv[i], {3{i[1]}}, e,
                {e == 8'h00, wv[i][3:0] <= fv[i][3:0], wv[i] <= fv[i]});
        end
    endtask : t_sub

    // Preset carry bits must survive the xor operations
    task automatic t_xor();
        logic [7:0] wv [4] = '{8'hA5, 8'h3C, 8'h00, 8'hFF};
        logic [7:0] kv [4] = '{8'h5A, 8'h3C, 8'hFF, 8'h0F};
        logic [2:0] s;
        for (int i = 0; i < 4; i++)
        begin
            s = {i[0], i[1], ~i[1]};
            run(BXA_OP_XORL, i[0], kv[i], wv[i], 8'h77, s, wv[i] ^ kv[i],
                {(wv[i] ^ kv[i]) == 8'h00, s[1:0]});
            run(BXA_OP_XORF, i[0], 8'h00, wv[i], kv[i], s, wv[i] ^ kv[i],
                {(wv[i] ^ kv[i]) == 8'h00, s[1:0]});
        end
    endtask : t_xor

    task automatic t_swap();
        logic [7:0] fv [3] = '{8'hA5, 8'h0F, 8'h00};
        for (int i = 0; i < 3; i++)
        begin
            run(BXA_OP_SWAP, i[0], 8'h00, 8'h3C, fv[i], {3{i[0]}},
                {fv[i][3:0], fv[i][7:4]}, {3{i[0]}});
        end
    endtask : t_swap

    initial
    begin
        repeat (5) @(posedge hclk);
        chk({31'h0, hreadyout}, 32'h1);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_sub();
        t_xor();
        t_swap();
        tally_and_finish();
    end

    // Whole run is a few hundred cycles
    initial
    begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
endmodule : tb
